// >>> hdl/ofm_pkg.sv
// Package of constants and types for the oscillator fail monitor.
package ofm_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_PRIO_STATUS = 8'ha9;
   localparam logic [7:0] REG_IRQ_STATUS  = 8'hb0;
   localparam logic [7:0] REG_IRQ_MASK    = 8'hb1;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned OSC_FAIL_BIT      = 7;
   localparam int unsigned WDT_FLAG_BIT      = 6;
   localparam int unsigned PRIO_MSB          = 5;
   localparam int unsigned IRQ_FAIL_BIT      = 0;
   localparam int unsigned IRQ_RECOVER_BIT   = 1;
   localparam int unsigned IRQ_W             = 2;
   localparam logic [7:0]  PRIO_STATUS_RESET = 8'h00;
   localparam logic [1:0]  IRQ_MASK_RESET    = 2'h0;
   localparam logic [1:0]  IRQ_STATUS_RESET  = 2'h0;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned REF_DIV            = 5;
   localparam int unsigned FINAL_PHASE_MS     = 1;
   localparam int unsigned FINAL_PHASE_CYCLES = FINAL_PHASE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int unsigned FINAL_CNT_W        = 17;
   localparam int unsigned SWITCH_GAP_CYCLES  = 4;
   localparam int unsigned GAP_CNT_W          = 3;
   localparam int unsigned REF_CNT_W          = 3;
   localparam int unsigned EDGE_CNT_W         = 3;
   localparam int unsigned SYNC_PINS          = 3;

   // ----------------------------------------------------------------
   // Supervisor states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_OFF,
      ST_MONITOR,
      ST_GAP_TO_RC,
      ST_FAIL,
      ST_FINAL,
      ST_GAP_TO_XTAL
   } ofm_state_t;

endpackage

// >>> hdl/ofm_cmp_if.sv
// Interface between the supervisor and the frequency comparator.
`timescale 1ns/1ps
interface ofm_cmp_if;
   logic run;
   logic window_done;
   logic xtal_slow;

   modport ctl (output run, input window_done, input xtal_slow);
   modport cmp (input run, output window_done, output xtal_slow);
endinterface

// >>> hdl/ofm_freq_cmp.sv
// Frequency comparator: crystal edges counted per divided reference period.
`timescale 1ns/1ps
module ofm_freq_cmp
   import ofm_pkg::*;
(
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic xtal_in,
   ofm_cmp_if.cmp    cmp
);

   logic                  xtal_meta_r;
   logic                  xtal_sync_r;
   logic                  xtal_last_r;
   logic [REF_CNT_W-1:0]  ref_cnt_r;
   logic [EDGE_CNT_W-1:0] edge_cnt_r;
   logic                  xtal_rise;
   logic                  ref_end;

   // ----------------------------------------------------------------
   // Pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      xtal_meta_r <= xtal_in;
      xtal_sync_r <= xtal_meta_r;
      xtal_last_r <= xtal_sync_r;
   end

   assign xtal_rise = xtal_sync_r & ~xtal_last_r;
   assign ref_end   = (ref_cnt_r == REF_CNT_W'(REF_DIV - 1));

   // ----------------------------------------------------------------
   // Reference divider and edge counter
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n || !cmp.run) begin
         ref_cnt_r <= '0;
      end else if (ref_end) begin
         ref_cnt_r <= '0;
      end else begin
         ref_cnt_r <= ref_cnt_r + 1'b1;
      end
   end

   // An edge in the closing cycle belongs to the next window, so none is lost.
   always_ff @(posedge clock) begin
      if (!reset_n || !cmp.run) begin
         edge_cnt_r <= '0;
      end else if (ref_end) begin
         edge_cnt_r <= {{(EDGE_CNT_W-1){1'b0}}, xtal_rise};
      end else if (xtal_rise && edge_cnt_r != '1) begin
         edge_cnt_r <= edge_cnt_r + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n || !cmp.run) begin
         cmp.window_done <= 1'b0;
         cmp.xtal_slow   <= 1'b1;
      end else begin
         cmp.window_done <= ref_end;
         if (ref_end) begin
            cmp.xtal_slow <= (edge_cnt_r == '0);
         end
      end
   end

endmodule

// >>> hdl/ofm_top.sv
// Oscillator fail monitor: supervision, clock select, reset and status flags.
`timescale 1ns/1ps
module ofm_top
   import ofm_pkg::*;
#(
   parameter int unsigned FINAL_CYCLES = FINAL_PHASE_CYCLES
)(
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        osc_monitor_enable_pin,
   input  wire logic        xtal_in,
   input  wire logic        ext_reset_n_pin,
   input  wire logic        hw_powerdown_pin,
   input  wire logic        wdt_reset_event,
   input  wire logic [7:0]  bus_addr,
   input  wire logic [7:0]  bus_wdata,
   input  wire logic        bus_write,
   input  wire logic        bus_read,
   output logic      [7:0]  bus_rdata,
   output logic             xtal_clk_en,
   output logic             rc_clk_en,
   output logic             chip_reset,
   output logic             wdt_stop,
   output logic      [5:0]  priority_bits,
   output logic             irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [SYNC_PINS-1:0]   pin_raw;
   logic [SYNC_PINS-1:0]   pin_meta_r;
   logic [SYNC_PINS-1:0]   pin_sync_r;
   logic                   enable_s;
   logic                   ext_reset_s;
   logic                   powerdown_s;

   ofm_state_t             state_r;
   ofm_state_t             state_nxt;
   logic [GAP_CNT_W-1:0]   gap_cnt_r;
   logic [FINAL_CNT_W-1:0] final_cnt_r;
   logic                   gap_done;
   logic                   final_done;
   logic                   fail_seen;
   logic                   good_seen;

   logic                   osc_reset_req_r;
   logic                   osc_reset_req_nxt;
   logic                   xtal_en_nxt;
   logic                   rc_en_nxt;

   logic                   osc_fail_flag_r;
   logic                   wdt_flag_r;
   logic [PRIO_MSB:0]      prio_r;
   logic [IRQ_W-1:0]       irq_status_r;
   logic [IRQ_W-1:0]       irq_mask_r;
   logic [IRQ_W-1:0]       irq_event;
   logic                   fail_enter;
   logic                   recover_done;

   ofm_cmp_if              cmp_bus ();

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
      hit = (addr == reg_addr);
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // The external reset is inverted here so that every synchronised bit is active high.
   assign pin_raw = {hw_powerdown_pin, ~ext_reset_n_pin, osc_monitor_enable_pin};

   generate
      for (genvar i = 0; i < SYNC_PINS; i++) begin : g_sync
         always_ff @(posedge clock) begin
            pin_meta_r[i] <= pin_raw[i];
            pin_sync_r[i] <= pin_meta_r[i];
         end
      end
   endgenerate

   assign enable_s    = pin_sync_r[0];
   assign ext_reset_s = pin_sync_r[1];
   assign powerdown_s = pin_sync_r[2];

   // ----------------------------------------------------------------
   // Frequency comparator
   // ----------------------------------------------------------------
   // The crystal is sampled by this clock, so it must run well below half its rate;
   // a faster crystal aliases and may read as slow.
   assign cmp_bus.run = enable_s;

   ofm_freq_cmp u_cmp (
      .clock   (clock),
      .reset_n (reset_n),
      .xtal_in (xtal_in),
      .cmp     (cmp_bus.cmp)
   );

   assign fail_seen = cmp_bus.window_done & cmp_bus.xtal_slow;
   assign good_seen = cmp_bus.window_done & ~cmp_bus.xtal_slow;

   // ----------------------------------------------------------------
   // Supervisor state machine
   // ----------------------------------------------------------------
   assign gap_done   = (gap_cnt_r == GAP_CNT_W'(SWITCH_GAP_CYCLES - 1));
   assign final_done = (final_cnt_r == FINAL_CNT_W'(FINAL_CYCLES - 1));

   // Power-down and power-on both start from the RC side and then follow
   // the same path as a detected failure, so the three functions share logic.
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_OFF: begin
            if (enable_s) begin
               state_nxt = ST_GAP_TO_RC;
            end
         end
         ST_MONITOR: begin
            if (!enable_s) begin
               state_nxt = ST_OFF;
            end else if (fail_seen || powerdown_s) begin
               state_nxt = ST_GAP_TO_RC;
            end
         end
         ST_GAP_TO_RC: begin
            if (!enable_s) begin
               state_nxt = ST_GAP_TO_XTAL;
            end else if (gap_done) begin
               state_nxt = ST_FAIL;
            end
         end
         ST_FAIL: begin
            if (!enable_s) begin
               state_nxt = ST_GAP_TO_XTAL;
            end else if (good_seen && !powerdown_s) begin
               state_nxt = ST_FINAL;
            end
         end
         ST_FINAL: begin
            if (!enable_s) begin
               state_nxt = ST_GAP_TO_XTAL;
            end else if (fail_seen || powerdown_s) begin
               state_nxt = ST_FAIL;
            end else if (final_done) begin
               state_nxt = ST_GAP_TO_XTAL;
            end
         end
         ST_GAP_TO_XTAL: begin
            if (gap_done) begin
               state_nxt = enable_s ? ST_MONITOR : ST_OFF;
            end
         end
         // Codes 6 and 7 cannot be reached; should one appear, the RC side is the safe way out.
         default: begin
            state_nxt = ST_GAP_TO_RC;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         state_r <= ST_GAP_TO_RC;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Dead-time and final phase counters
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n || state_nxt != state_r) begin
         gap_cnt_r <= '0;
      end else if ((state_r == ST_GAP_TO_RC || state_r == ST_GAP_TO_XTAL) && !gap_done) begin
         gap_cnt_r <= gap_cnt_r + 1'b1;
      end
   end

   // A slow window during the final phase restarts the whole phase.
   always_ff @(posedge clock) begin
      if (!reset_n || state_r != ST_FINAL) begin
         final_cnt_r <= '0;
      end else if (!final_done) begin
         final_cnt_r <= final_cnt_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Clock enables and reset request
   // ----------------------------------------------------------------
   // Neither enable is high inside a gap state, so the outside AND-OR
   // clock cell never sees both sources at once.
   always_comb begin
      xtal_en_nxt       = (state_nxt == ST_OFF) || (state_nxt == ST_MONITOR);
      rc_en_nxt         = (state_nxt == ST_FAIL) || (state_nxt == ST_FINAL);
      osc_reset_req_nxt = enable_s &&
                          (state_nxt == ST_GAP_TO_RC || state_nxt == ST_FAIL ||
                           state_nxt == ST_FINAL || state_nxt == ST_GAP_TO_XTAL);
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         xtal_clk_en <= 1'b0;
         rc_clk_en   <= 1'b0;
      end else begin
         xtal_clk_en <= xtal_en_nxt;
         rc_clk_en   <= rc_en_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         osc_reset_req_r <= 1'b1;
      end else begin
         osc_reset_req_r <= osc_reset_req_nxt;
      end
   end

   // The external reset reaches the chip late through its synchroniser, so a pulse
   // shorter than one clock period may be missed.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         chip_reset <= 1'b1;
      end else begin
         chip_reset <= osc_reset_req_nxt | ext_reset_s;
      end
   end

   // The watchdog stop follows the monitor's own request alone.
   assign wdt_stop = osc_reset_req_r;

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   assign fail_enter   = (state_r == ST_MONITOR) && (state_nxt == ST_GAP_TO_RC) && !powerdown_s;
   assign recover_done = (state_r == ST_GAP_TO_XTAL) && (state_nxt == ST_MONITOR);

   // Hardware set wins over any clear in the same cycle.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         osc_fail_flag_r <= PRIO_STATUS_RESET[OSC_FAIL_BIT];
      end else if (fail_enter) begin
         osc_fail_flag_r <= 1'b1;
      end else if (ext_reset_s) begin
         osc_fail_flag_r <= 1'b0;
      end else if (bus_write && hit(bus_addr, REG_PRIO_STATUS)) begin
         osc_fail_flag_r <= bus_wdata[OSC_FAIL_BIT];
      end
   end

   // The monitor reset deliberately has no path into this flag.
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         wdt_flag_r <= PRIO_STATUS_RESET[WDT_FLAG_BIT];
      end else if (wdt_reset_event) begin
         wdt_flag_r <= 1'b1;
      end else if (ext_reset_s) begin
         wdt_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         prio_r <= PRIO_STATUS_RESET[PRIO_MSB:0];
      end else if (bus_write && hit(bus_addr, REG_PRIO_STATUS)) begin
         prio_r <= bus_wdata[PRIO_MSB:0];
      end
   end

   assign priority_bits = prio_r;

   // ----------------------------------------------------------------
   // Interrupt status and mask
   // ----------------------------------------------------------------
   always_comb begin
      irq_event                  = '0;
      irq_event[IRQ_FAIL_BIT]    = fail_enter;
      irq_event[IRQ_RECOVER_BIT] = recover_done;
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq_status_r <= IRQ_STATUS_RESET;
      end else if (bus_write && hit(bus_addr, REG_IRQ_STATUS)) begin
         irq_status_r <= (irq_status_r & ~bus_wdata[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_status_r <= irq_status_r | irq_event;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq_mask_r <= IRQ_MASK_RESET;
      end else if (bus_write && hit(bus_addr, REG_IRQ_MASK)) begin
         irq_mask_r <= bus_wdata[IRQ_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

   // ----------------------------------------------------------------
   // Register read port
   // ----------------------------------------------------------------
   // Read data stand for one cycle after each cycle that bus_read is high; unmapped addresses read zero.
   always_ff @(posedge clock) begin
      if (!reset_n || !bus_read) begin
         bus_rdata <= 8'h00;
      end else if (hit(bus_addr, REG_PRIO_STATUS)) begin
         bus_rdata <= {osc_fail_flag_r, wdt_flag_r, prio_r};
      end else if (hit(bus_addr, REG_IRQ_STATUS)) begin
         bus_rdata <= {{(8-IRQ_W){1'b0}}, irq_status_r};
      end else if (hit(bus_addr, REG_IRQ_MASK)) begin
         bus_rdata <= {{(8-IRQ_W){1'b0}}, irq_mask_r};
      end else begin
         bus_rdata <= 8'h00;
      end
   end

endmodule

// >>> sim/ofm_xtal_model.sv
// Behavioural crystal oscillator and external reset source facing the monitor.
`timescale 1ns/1ps
module ofm_xtal_model (
   input  wire logic clock,
   input  wire logic run,
   input  wire logic hold_reset,
   output logic      xtal_in,
   output logic      ext_reset_n_pin
);
   logic [1:0] phase_r = 2'h0;

   // A dead crystal freezes at its last level, so no edge may reach the comparator.
   always @(posedge clock) begin
      if (run) begin
         phase_r <= phase_r + 2'h1;
      end
   end

   // One rising edge every four cycles keeps a running crystal above the reference.
   assign xtal_in         = phase_r[1];
   assign ext_reset_n_pin = !hold_reset;
endmodule

// >>> sim/ofm_top_properties.sv
// Port checker for the oscillator fail monitor.
`timescale 1ns/1ps
module ofm_top_properties
   import ofm_pkg::*;
#(
   parameter int unsigned FINAL_CYCLES = FINAL_PHASE_CYCLES
)(
   input wire logic       clock,
   input wire logic       reset_n,
   input wire logic       osc_monitor_enable_pin,
   input wire logic       xtal_in,
   input wire logic       ext_reset_n_pin,
   input wire logic       hw_powerdown_pin,
   input wire logic       wdt_reset_event,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic       bus_write,
   input wire logic       bus_read,
   input wire logic [7:0] bus_rdata,
   input wire logic       xtal_clk_en,
   input wire logic       rc_clk_en,
   input wire logic       chip_reset,
   input wire logic       wdt_stop,
   input wire logic [5:0] priority_bits,
   input wire logic       irq
);
   int unsigned up_cnt_r;
   int unsigned off_cnt_r;
   int unsigned rc_cnt_r;

   // ----------------------------------------------------------------
   // Helper counters
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!reset_n) up_cnt_r <= 0;
      else if (up_cnt_r < 1000) up_cnt_r <= up_cnt_r + 1;
   end
   always_ff @(posedge clock) begin
      if (!reset_n || osc_monitor_enable_pin) off_cnt_r <= 0;
      else if (off_cnt_r < 1000) off_cnt_r <= off_cnt_r + 1;
   end
   // Counts how long the RC source has fed the tree without a break.
   always_ff @(posedge clock) begin
      if (!reset_n || !rc_clk_en) rc_cnt_r <= 0;
      else rc_cnt_r <= rc_cnt_r + 1;
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   clk_exclusive_a: assert property (!(xtal_clk_en && rc_clk_en))
      else $error("both clock sources enabled");
   rc_held_reset_a: assert property (rc_clk_en |-> chip_reset && wdt_stop)
      else $error("RC clock without reset or watchdog stop");
   wdt_stop_reset_a: assert property (wdt_stop |-> chip_reset)
      else $error("watchdog stopped outside reset");
   switch_to_rc_a: assert property ($fell(xtal_clk_en) |-> ##[3:5] rc_clk_en)
      else $error("RC source not selected after crystal drop");
   final_phase_a: assert property ($fell(rc_clk_en) |-> $past(rc_cnt_r) >= FINAL_CYCLES)
      else $error("final reset phase too short");
   back_to_xtal_a: assert property ($fell(rc_clk_en) |-> ##[1:6] xtal_clk_en)
      else $error("crystal not reselected");
   ext_reset_hold_a: assert property ((up_cnt_r >= 4 && !ext_reset_n_pin
      && !$past(ext_reset_n_pin) && !$past(ext_reset_n_pin, 2)
      && !$past(ext_reset_n_pin, 3)) |-> chip_reset)
      else $error("external reset not honoured");
   disabled_idle_a: assert property ((off_cnt_r >= 16 && ext_reset_n_pin
      && $past(ext_reset_n_pin) && $past(ext_reset_n_pin, 2) && $past(ext_reset_n_pin, 3))
      |-> xtal_clk_en && !rc_clk_en && !chip_reset)
      else $error("disabled unit touches clock or reset");
   rdata_idle_a: assert property (!$past(bus_read) |-> bus_rdata == 8'h00)
      else $error("read data outside read slot");
endmodule

bind ofm_top ofm_top_properties #(.FINAL_CYCLES(FINAL_CYCLES)) u_props (
   .clock(clock), .reset_n(reset_n), .osc_monitor_enable_pin(osc_monitor_enable_pin),
   .xtal_in(xtal_in), .ext_reset_n_pin(ext_reset_n_pin), .hw_powerdown_pin(hw_powerdown_pin),
   .wdt_reset_event(wdt_reset_event), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
   .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
   .xtal_clk_en(xtal_clk_en), .rc_clk_en(rc_clk_en), .chip_reset(chip_reset),
   .wdt_stop(wdt_stop), .priority_bits(priority_bits), .irq(irq));

// >>> sim/tb_top.sv
// Self-checking testbench of the oscillator fail monitor.
`timescale 1ns/1ps
module tb_top
   import ofm_pkg::*;
   ;
   localparam int FC = 50;
   logic       clock, reset_n, en, xtal_run, ext_hold, hw_pd, wdt_ev;
   logic       xtal_in, ext_reset_n_pin;
   logic [7:0] bus_addr, bus_wdata, bus_rdata;
   logic       bus_write, bus_read, xtal_clk_en, rc_clk_en, chip_reset, wdt_stop, irq;
   logic [5:0] priority_bits;
   int         miscompares, total_checks, cyc, n;

   ofm_xtal_model u_xtal (.clock(clock), .run(xtal_run), .hold_reset(ext_hold),
      .xtal_in(xtal_in), .ext_reset_n_pin(ext_reset_n_pin));
   ofm_top #(.FINAL_CYCLES(FC)) DUT (.clock(clock), .reset_n(reset_n),
      .osc_monitor_enable_pin(en), .xtal_in(xtal_in), .ext_reset_n_pin(ext_reset_n_pin),
      .hw_powerdown_pin(hw_pd), .wdt_reset_event(wdt_ev), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read),
      .bus_rdata(bus_rdata), .xtal_clk_en(xtal_clk_en), .rc_clk_en(rc_clk_en),
      .chip_reset(chip_reset), .wdt_stop(wdt_stop), .priority_bits(priority_bits), .irq(irq));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_write <= 1'b1;
      @(posedge clock);
      bus_write <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clock);
      bus_read <= 1'b0;
      #1;
      check(bus_rdata, exp);
   endtask
   // Waits under a bound for rc_clk_en (0), xtal_clk_en (1) or chip_reset (2).
   task automatic wait_for(input int sel, input logic lvl, input int lim, output int cnt);
      logic s;
      cnt = 0;
      do begin
         @(posedge clock);
         #1;
         s = (sel == 0) ? rc_clk_en : (sel == 1) ? xtal_clk_en : chip_reset;
         cnt++;
      end while (s !== lvl && cnt < lim);
      check({7'h00, s}, {7'h00, lvl});
   endtask
   task automatic recover();
      wait_for(1, 1'b1, FC + 80, n);
      check({7'h00, n >= FC}, 8'h01);
      wait_for(2, 1'b0, 10, n);
   endtask
   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // The run needs under a thousand cycles; the ceiling leaves a wide margin.
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         results();
      end
   end

   initial begin
      {reset_n, xtal_run, ext_hold, hw_pd, wdt_ev, bus_write, bus_read} = 7'h00;
      {bus_addr, bus_wdata} = 16'h0000;
      en = 1'b1;
      repeat (6) @(posedge clock);
      reset_n <= 1'b1;
      wait_for(0, 1'b1, 40, n);
      rd(REG_PRIO_STATUS, PRIO_STATUS_RESET);
      rd(REG_IRQ_STATUS, 8'h00);
      rd(REG_IRQ_MASK, 8'h00);
      rd(8'h10, 8'h00);
      xtal_run <= 1'b1;
      recover();
      rd(REG_IRQ_STATUS, 8'h02);
      wr(REG_IRQ_STATUS, 8'h02);
      $display("Power-on test done");
      wr(REG_PRIO_STATUS, 8'h2a);
      rd(REG_PRIO_STATUS, 8'h2a);
      check({2'b00, priority_bits}, 8'h2a);
      wr(REG_PRIO_STATUS, 8'h80);
      rd(REG_PRIO_STATUS, 8'h80);
      wr(REG_PRIO_STATUS, 8'h00);
      rd(REG_PRIO_STATUS, 8'h00);
      @(posedge clock);
      wdt_ev <= 1'b1;
      @(posedge clock);
      wdt_ev <= 1'b0;
      wr(REG_PRIO_STATUS, 8'h00);
      rd(REG_PRIO_STATUS, 8'h40);
      $display("Register test done");
      wr(REG_IRQ_MASK, 8'h01);
      xtal_run <= 1'b0;
      wait_for(1, 1'b0, 20, n);
      wait_for(0, 1'b1, 10, n);
      check({5'h00, irq, wdt_stop, chip_reset}, 8'h07);
      rd(REG_PRIO_STATUS, 8'hc0);
      rd(REG_IRQ_STATUS, 8'h01);
      xtal_run <= 1'b1;
      recover();
      check({7'h00, wdt_stop}, 8'h00);
      rd(REG_IRQ_STATUS, 8'h03);
      wr(REG_IRQ_STATUS, 8'h01);
      rd(REG_IRQ_STATUS, 8'h02);
      check({7'h00, irq}, 8'h00);
      wr(REG_IRQ_MASK, 8'h02);
      repeat (2) @(posedge clock);
      check({7'h00, irq}, 8'h01);
      wr(REG_IRQ_STATUS, 8'h02);
      rd(REG_IRQ_STATUS, 8'h00);
      check({7'h00, irq}, 8'h00);
      $display("Failure test done");
      ext_hold <= 1'b1;
      xtal_run <= 1'b0;
      wait_for(0, 1'b1, 30, n);
      xtal_run <= 1'b1;
      wait_for(1, 1'b1, FC + 80, n);
      repeat (5) @(posedge clock);
      check({7'h00, chip_reset}, 8'h01);
      ext_hold <= 1'b0;
      wait_for(2, 1'b0, 6, n);
      rd(REG_PRIO_STATUS, 8'h00);
      $display("External reset test done");
      en <= 1'b0;
      repeat (20) @(posedge clock);
      xtal_run <= 1'b0;
      repeat (30) @(posedge clock);
      check({5'h00, xtal_clk_en, rc_clk_en, chip_reset}, 8'h04);
      rd(REG_PRIO_STATUS, 8'h00);
      xtal_run <= 1'b1;
      en <= 1'b1;
      wait_for(0, 1'b1, 15, n);
      recover();
      check({5'h00, xtal_clk_en, rc_clk_en, chip_reset}, 8'h04);
      $display("Disable test done");
      hw_pd <= 1'b1;
      wait_for(0, 1'b1, 40, n);
      rd(REG_PRIO_STATUS, 8'h00);
      hw_pd <= 1'b0;
      recover();
      $display("Power-down test done");
      results();
   end
endmodule
